// >>> common/icache_defines.svh
// Offsets, field positions and reset values of the instruction cache controller
// Assumes a byte-addressed register port of eight address bits
`ifndef ICACHE_DEFINES_SVH
`define ICACHE_DEFINES_SVH

`define ICD_REG_AW        8
`define ICD_CTRL_OFS      8'h00
`define ICD_LOCK_OFS      8'h04
`define ICD_INVAL_OFS     8'h08
`define ICD_STAT_OFS      8'h0c

`define ICD_CTRL_XLAT_BIT 0
`define ICD_CTRL_EN_BIT   12
`define ICD_CTRL_RR_BIT   14
`define ICD_CTRL_RESET    32'h0000_0000
`define ICD_LOCK_LSB      26
`define ICD_LOCK_MSB      31

`define ICD_SEGS          4
`define ICD_WAYS          64
`define ICD_LINES         256
`define ICD_WORDS         8
`define ICD_TAG_W         25
`define ICD_WAY_MAX       6'h3f
`define ICD_LAST_WORD     3'h7
`define ICD_LFSR_SEED     6'h2d

`endif

// >>> common/icache_pkg.sv
// Types shared by the instruction cache controller and its helpers
// Assumes icache_defines.svh is on the include path
package icache_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_DONE  = 5'b01000,
    ST_FLUSH = 5'b10000
  } state_type;

  // System bus transfer codes; the no-address-yet code is never used
  typedef enum logic [1:0] {
    TRAN_IDLE = 2'b00,
    TRAN_N    = 2'b01,
    TRAN_A    = 2'b10,
    TRAN_S    = 2'b11
  } tran_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } size_type;

endpackage

// >>> rtl/tag_match.sv
// Tag compare across the 64 ways of one segment
// Assumes tags and valid bits are flat vectors indexed by {segment, way}
`include "icache_defines.svh"
`timescale 1ns/10ps
module tag_match
  import icache_pkg::*;
(
  input  wire logic [`ICD_LINES*`ICD_TAG_W-1:0] tag_flat,
  input  wire logic [`ICD_LINES-1:0]            valid,
  input  wire logic [1:0]                       seg,
  input  wire logic [`ICD_TAG_W-1:0]            tag,
  output logic                                  hit,
  output logic [5:0]                            way
);
  logic [`ICD_WAYS-1:0] match;

  genvar i;
  generate
    for (i = 0; i < `ICD_WAYS; i = i + 1) begin : g_way
      wire [7:0] line = {seg, 6'(i)};
      assign match[i] = valid[line] &&
                        (tag_flat[line*`ICD_TAG_W +: `ICD_TAG_W] == tag);
    end
  endgenerate

  assign hit = |match;

  // A tag lives in at most one way; the encoder only has to name it
  always_comb begin
    way = 6'h00;
    for (int k = 0; k < `ICD_WAYS; k = k + 1) begin
      if (match[k]) begin
        way = 6'(k);
      end
    end
  end
endmodule

// >>> rtl/victim_picker.sv
// Victim choice for linefills: free running random source and per-segment pointers
// Assumes advance is a one-cycle pulse at the end of each linefill
`include "icache_defines.svh"
`timescale 1ns/10ps
module victim_picker
  import icache_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rr_mode,
  input  wire logic [5:0] base,
  input  wire logic       load,
  input  wire logic [5:0] load_val,
  input  wire logic [1:0] seg,
  input  wire logic       advance,
  output logic [5:0]      victim
);
  logic [5:0] lfsr;
  logic [5:0] ptr [0:`ICD_SEGS-1];
  wire  [5:0] rand_way = lfsr | base;
  wire  [5:0] rr_way   = (ptr[seg] < base) ? base : ptr[seg];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr <= `ICD_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[4:0], lfsr[5] ^ lfsr[4]};
    end
  end

  // OR with the base keeps the random pick at or above the lockdown base
  assign victim = rr_mode ? rr_way : rand_way;

  genvar s;
  generate
    for (s = 0; s < `ICD_SEGS; s = s + 1) begin : g_seg
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ptr[s] <= 6'h00;
        end else if (load) begin
          ptr[s] <= load_val;
        end else if (advance && seg == 2'(s)) begin
          ptr[s] <= (victim == `ICD_WAY_MAX) ? base : victim + 6'h01;
        end
      end
    end
  endgenerate
endmodule

// >>> rtl/icache_ctrl.sv
// Level-one instruction cache controller: lookup, linefill, noncached fetch, registers
// Assumes fetch port, register port and system bus all run on CLK_SYS
//
// How it works
// - 256 lines of 32 bytes, 64-way associative, looked up by modified address.
// - Four segments of 64 lines; address bits 6:5 pick the segment.
// - Bits 4:2 pick the word; bit 1 the halfword; bits 1:0 the byte.
// - Tag is address bits 31:7; hit needs a valid matching tag.
// - One valid bit and eight data words per line.
// - Reset invalidates every line and leaves the cache off.
// - Control bit 12 switches the cache on when 1, off when 0.
// - When off, contents ignored, not updated, each fetch one bus access.
// - Switching off and on again keeps all stored lines except the victim of a fill running at switch-off.
// - Translation off: every fetch cachable, no checks, address used as is.
// - When on, every fetch is looked up regardless of cachable attribute.
// - Cachable hit returns the instruction with no bus access.
// - Cachable miss fills eight words into an unlocked victim.
// - Noncachable fetch is one bus access and allocates nothing.
// - Rejected fetches cause no linefill and no bus fetch.
// - Bus accesses are an address cycle followed by sequential cycles.
// - The no-address transfer code is never driven.
// - Random victim after reset, round-robin per segment when bit 14 set.
// - Lockdown in units of one way; locked ways never become victims.
// - One control write sets translation and cache enable together.
// - With a lockdown base set, victims come from base up to 63.
`include "icache_defines.svh"
`timescale 1ns/10ps
module icache_ctrl
  import icache_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  input  wire logic [`ICD_REG_AW-1:0] REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [31:0]                REG_RDATA,
  input  wire logic                  FETCH_REQ,
  input  wire logic [31:0]           FETCH_ADDR,
  input  wire logic [1:0]            FETCH_SIZE,
  input  wire logic                  FETCH_CACHABLE,
  input  wire logic                  FETCH_ABORT,
  output logic                       FETCH_READY,
  output logic                       FETCH_FAULT,
  output logic [31:0]                FETCH_DATA,
  output logic [1:0]                 BUS_TRANS,
  output logic [31:0]                BUS_ADDR,
  input  wire logic [31:0]           BUS_RDATA,
  input  wire logic                  BUS_WAIT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [31:0]                   data_mem [0:`ICD_LINES*`ICD_WORDS-1];
  logic [`ICD_LINES*`ICD_TAG_W-1:0] tag_flat;
  logic [`ICD_LINES-1:0]         valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [31:0] ctrl;
  logic [5:0]  lock_base;
  state_type   state;
  state_type   next_state;
  logic        fill;
  logic [31:0] req_addr;
  logic [1:0]  req_size;
  logic [2:0]  word_cnt;
  logic [5:0]  fill_way;
  logic        fault;
  logic        last_hit;
  logic [31:0] fetch_word;
  logic [31:0] rdata;
  logic [31:0] req_addr_bus;
  logic        fill_keep;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  wire cache_on = ctrl[`ICD_CTRL_EN_BIT];
  wire xlat_on  = ctrl[`ICD_CTRL_XLAT_BIT];
  wire rr_mode  = ctrl[`ICD_CTRL_RR_BIT];

  wire [1:0]  seg      = FETCH_ADDR[6:5];
  wire [2:0]  word_sel = FETCH_ADDR[4:2];
  wire [24:0] tag      = FETCH_ADDR[31:7];

  // Translation off: flat address, always cachable, never rejected
  wire cachable = xlat_on ? FETCH_CACHABLE : 1'b1;
  wire rejected = xlat_on & FETCH_ABORT;

  wire       hit;
  wire [5:0] hit_way;
  wire [5:0] victim;

  tag_match u_match (
    .tag_flat (tag_flat),
    .valid    (valid),
    .seg      (seg),
    .tag      (tag),
    .hit      (hit),
    .way      (hit_way)
  );

  // Lookup on every enabled fetch; a hit counts only when cachable
  wire lookup   = cache_on;
  wire use_hit  = lookup & hit & cachable;
  wire do_fill  = lookup & ~hit & cachable;
  wire take_req = (state == ST_IDLE) & FETCH_REQ;

  wire [10:0] hit_index = {seg, hit_way, word_sel};
  wire [31:0] hit_word  = data_mem[hit_index];

  wire [7:0]  fill_line = {req_addr[6:5], fill_way};
  wire [10:0] fill_index = {fill_line, word_cnt};
  wire        word_in   = (state == ST_DATA) & ~BUS_WAIT;
  wire        last_word = ~fill | (word_cnt == `ICD_LAST_WORD);
  wire        fill_end  = word_in & fill & last_word;
  wire        want_word = ~fill | (word_cnt == req_addr[4:2]);

  wire reg_wr_ctrl  = REG_WR & (REG_ADDR == `ICD_CTRL_OFS);
  wire reg_wr_lock  = REG_WR & (REG_ADDR == `ICD_LOCK_OFS);
  wire reg_wr_inval = REG_WR & (REG_ADDR == `ICD_INVAL_OFS);
  wire [5:0] lock_val = REG_WDATA[`ICD_LOCK_MSB:`ICD_LOCK_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Victim choice

  victim_picker u_victim (
    .clk      (CLK_SYS),
    .reset    (RESET),
    .rr_mode  (rr_mode),
    .base     (lock_base),
    .load     (reg_wr_lock),
    .load_val (lock_val),
    .seg      (take_req ? seg : req_addr[6:5]),
    .advance  (fill_end),
    .victim   (victim)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Lane select for narrow fetches

  function automatic logic [31:0] lane(input logic [31:0] w,
                                       input logic [1:0]  a,
                                       input logic [1:0]  sz);
    logic [31:0] r;
    r = w;
    if (sz == SIZE_BYTE) begin
      r = {24'h00_0000, w[8*a +: 8]};
    end else if (sz == SIZE_HALF) begin
      r = {16'h0000, w[16*a[1] +: 16]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (FETCH_REQ) begin
          if (rejected || use_hit) begin
            next_state = ST_DONE;
          end else begin
            next_state = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        next_state = ST_DATA;
      end
      ST_DATA: begin
        if (word_in && last_word) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      ST_FLUSH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The address cycle, then sequential cycles; the other code never leaves here
  assign BUS_TRANS = (state == ST_ADDR) ? TRAN_A :
                     (state == ST_DATA) ? TRAN_S : TRAN_IDLE;
  assign BUS_ADDR  = req_addr_bus;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      req_addr     <= 32'h0000_0000;
      req_size     <= 2'h0;
      req_addr_bus <= 32'h0000_0000;
      fill         <= 1'b0;
      fill_way     <= 6'h00;
      word_cnt     <= 3'h0;
    end else if (take_req) begin
      req_addr <= FETCH_ADDR;
      req_size <= FETCH_SIZE;
      fill     <= do_fill;
      fill_way <= victim;
      word_cnt <= 3'h0;
      // Disabled or noncachable: one word at the fetch address
      if (do_fill) begin
        req_addr_bus <= {FETCH_ADDR[31:5], 5'h00};
      end else begin
        req_addr_bus <= {FETCH_ADDR[31:2], 2'h0};
      end
    end else if (word_in) begin
      word_cnt     <= word_cnt + 3'h1;
      req_addr_bus <= req_addr_bus + 32'h0000_0004;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Linefill writes; noncached fetches never touch the store

  always_ff @(posedge CLK_SYS) begin
    if (word_in && fill) begin
      data_mem[fill_index] <= BUS_RDATA;
    end
  end

  // Having the cache off in a cycle before the last word's cycle leaves tag and valid unwritten; the words still overwrite the victim's data
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      fill_keep <= 1'b0;
    end else if (take_req) begin
      fill_keep <= do_fill;
    end else if (!cache_on) begin
      fill_keep <= 1'b0;
    end
  end

  wire keep_line = fill_end & fill_keep;

  // Invalidate-all clears first, so a fill ending in the same cycle survives
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      valid <= '0;
    end else begin
      if (reg_wr_inval) begin
        valid <= '0;
      end
      if (keep_line) begin
        valid[fill_line] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tag_flat <= '0;
    end else if (keep_line) begin
      tag_flat[fill_line*`ICD_TAG_W +: `ICD_TAG_W] <= req_addr[31:7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer to the core

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      fetch_word <= 32'h0000_0000;
      fault      <= 1'b0;
      last_hit   <= 1'b0;
    end else if (take_req) begin
      fault    <= rejected;
      last_hit <= use_hit & ~rejected;
      if (use_hit && !rejected) begin
        fetch_word <= lane(hit_word, FETCH_ADDR[1:0], FETCH_SIZE);
      end
    end else if (word_in && want_word) begin
      fetch_word <= lane(BUS_RDATA, req_addr[1:0], req_size);
    end
  end

  assign FETCH_READY = (state == ST_DONE);
  assign FETCH_FAULT = (state == ST_DONE) & fault;
  assign FETCH_DATA  = fetch_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  wire [31:0] ctrl_mask = (32'h1 << `ICD_CTRL_XLAT_BIT) |
                          (32'h1 << `ICD_CTRL_EN_BIT) |
                          (32'h1 << `ICD_CTRL_RR_BIT);

  // A single write updates both enables, so they switch in the same cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl      <= `ICD_CTRL_RESET;
      lock_base <= 6'h00;
    end else begin
      if (reg_wr_ctrl) begin
        ctrl <= REG_WDATA & ctrl_mask;
      end
      if (reg_wr_lock) begin
        lock_base <= lock_val;
      end
    end
  end

  wire rd_ctrl = (REG_ADDR == `ICD_CTRL_OFS);
  wire rd_lock = (REG_ADDR == `ICD_LOCK_OFS);
  wire rd_stat = (REG_ADDR == `ICD_STAT_OFS);

  wire [31:0] stat_word = {16'h0000, fill_way, fault, last_hit, 3'h0, state};
  wire [31:0] lock_word = {lock_base, 20'h0_0000, victim};

  wire [31:0] rd_mux = rd_ctrl ? ctrl :
                       rd_lock ? lock_word :
                       rd_stat ? stat_word : 32'h0000_0000;

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rdata <= 32'h0000_0000;
    end else if (REG_RD) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata;

endmodule

// >>> verif/icache_ctrl_sva.sv
// Concurrent checks on the fetch port and system bus of icache_ctrl
// Assumes one clock domain; bound onto icache_ctrl from the bench top file
`timescale 1ns/10ps
module icache_ctrl_sva
  import icache_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        FETCH_REQ,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic        FETCH_READY,
  input wire logic        FETCH_FAULT,
  input wire logic [1:0]  BUS_TRANS,
  input wire logic [31:0] BUS_ADDR,
  input wire logic        BUS_WAIT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////
  // Words taken since the last address cycle; judged when a burst ends
  logic [3:0] words;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET)
      words <= 4'h0;
    else if (BUS_TRANS == TRAN_A)
      words <= 4'h0;
    else if (BUS_TRANS == TRAN_S && !BUS_WAIT)
      words <= words + 4'h1;
  end
  ////////////////////////////////////////////////
  AST_NO_NTRAN: assert property (BUS_TRANS != TRAN_N)
    else $error("unused transfer code driven");
  AST_A_THEN_S: assert property (BUS_TRANS == TRAN_A |=> BUS_TRANS == TRAN_S)
    else $error("address cycle without sequential cycle");
  AST_WAIT_HOLD: assert property (BUS_TRANS == TRAN_S && BUS_WAIT |=>
    BUS_TRANS == TRAN_S && $stable(BUS_ADDR))
    else $error("bus cycle dropped during stall");
  AST_SEQ_STEP: assert property ($past(BUS_TRANS) == TRAN_S && !$past(BUS_WAIT) &&
    BUS_TRANS == TRAN_S |-> BUS_ADDR == $past(BUS_ADDR) + 32'h4)
    else $error("linefill address did not step by four");
  AST_BURST_LEN: assert property ($past(BUS_TRANS) == TRAN_S && BUS_TRANS != TRAN_S
    |-> FETCH_READY && (words == 4'h1 || words == 4'h8))
    else $error("burst length neither one nor eight");
  AST_ADDR_FLAT: assert property (BUS_TRANS == TRAN_A |-> FETCH_REQ &&
    BUS_ADDR[31:5] == FETCH_ADDR[31:5])
    else $error("bus address differs from fetch address");
  AST_FAULT_QUIET: assert property (FETCH_FAULT |->
    FETCH_READY && $past(BUS_TRANS) == TRAN_IDLE)
    else $error("rejected fetch reached the bus");
  AST_RESET_QUIET: assert property ($fell(RESET) |->
    BUS_TRANS == TRAN_IDLE && !FETCH_READY ##1 !FETCH_READY)
    else $error("activity right after reset");
  CV_FAULT: cover property (FETCH_FAULT);
  CV_FILL: cover property (words == 4'h8 && BUS_TRANS == TRAN_IDLE);
  CV_STALL: cover property (BUS_TRANS == TRAN_S && BUS_WAIT);
endmodule

// >>> verif/sys_bus_model.sv
// Behavioural memory on the system bus side of the cache controller
// Assumes the word at an address is the address xor a fixed mask
`timescale 1ns/10ps
module sys_bus_model
  import icache_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [1:0]  trans,
  input  wire logic [31:0] addr,
  output logic [31:0]      rdata,
  output logic             stall
);
  logic [3:0]  lfsr = 4'h9;
  logic [31:0] noise = 32'h0;
  always @(posedge clk) begin
    lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    noise <= noise + 32'h9e37_79b9;
  end
  assign stall = slow & lfsr[0];
  // Off a taken word the lines churn, so a stale sample never looks right
  assign rdata = (trans == TRAN_S && !stall) ? addr ^ 32'hc3a5_0f96 : noise;
endmodule

// >>> verif/test_instruction_cache_controller.sv
// Self-checking bench for icache_ctrl with a memory model on the bus
// Assumes the checker is bound in below and icache_defines.svh is on the path
`timescale 1ns/10ps
module test_instruction_cache_controller
  import icache_pkg::*;
();
  logic        clk = 1'b0, rst = 1'b1, rwr = 1'b0, rrd = 1'b0, slow = 1'b0;
  logic        freq = 1'b0, fcach = 1'b1, fabt = 1'b0, frdy, ffault, bwait;
  logic [7:0]  ra = 8'h00;
  logic [1:0]  fsz = 2'h2, btr, s;
  logic [31:0] rwd = 32'h0, fadr = 32'h0, rdat, fdat, badr, brd, v, a;
  bit   [3:0]  res [4];
  int          bad_count = 0, compares = 0, a_cnt = 0, t, g;
  always #25 clk = ~clk;
  always @(posedge clk) if (btr === TRAN_A) a_cnt++;
  icache_ctrl dut (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(ra), .REG_WDATA(rwd),
    .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat), .FETCH_REQ(freq), .FETCH_ADDR(fadr),
    .FETCH_SIZE(fsz), .FETCH_CACHABLE(fcach), .FETCH_ABORT(fabt), .FETCH_READY(frdy),
    .FETCH_FAULT(ffault), .FETCH_DATA(fdat), .BUS_TRANS(btr), .BUS_ADDR(badr),
    .BUS_RDATA(brd), .BUS_WAIT(bwait));
  sys_bus_model bus_i (.clk(clk), .slow(slow), .trans(btr), .addr(badr), .rdata(brd),
    .stall(bwait));
  ////////////////////////////////////////////////
  function automatic logic [31:0] exp_data(input logic [31:0] ad, input logic [1:0] sz);
    logic [31:0] w;
    w = {ad[31:2], 2'h0} ^ 32'hc3a5_0f96;
    if (sz == SIZE_WORD)
      return w;
    if (sz == SIZE_HALF)
      return (w >> (ad[1] * 16)) & 32'hffff;
    return (w >> (ad[1:0] * 8)) & 32'hff;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    ra <= ad;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    ra <= ad;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(negedge clk);
    d = rdat;
    @(posedge clk);
  endtask
  // Request held until the ready edge; one idle edge keeps strobes apart
  task automatic fetch(input logic [31:0] ad, input logic [1:0] sz, input logic c, ab, nb);
    int n, a0;
    a0 = a_cnt;
    n = 0;
    freq <= 1'b1;
    fadr <= ad;
    fsz <= sz;
    fcach <= c;
    fabt <= ab;
    do begin
      @(posedge clk);
      n++;
    end while (frdy !== 1'b1 && n < 100);
    freq <= 1'b0;
    chk(n < 100, 1'b1);
    chk(ffault, ab);
    if (!ab)
      chk(fdat, exp_data(ad, sz));
    chk(a_cnt - a0, nb);
    @(posedge clk);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////
  initial begin
    #2_000_000;
    bad_count++;
    end_of_test;
  end
  initial begin
    void'($urandom(72));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, v);
    chk(v, 32'h0);
    rd(8'h10, v);
    chk(v, 32'h0);
    a = 32'h0000_1234;
    fetch(a, SIZE_WORD, 1, 0, 1);
    fetch(a, SIZE_BYTE, 1, 0, 1);
    wr(8'h00, 32'h1000);
    fetch(a, SIZE_HALF, 1, 0, 1);
    fetch(a ^ 32'h1c, SIZE_WORD, 1, 0, 0);
    fetch(a ^ 32'h80, SIZE_WORD, 1, 0, 1);
    wr(8'h00, 32'h0);
    fetch(a, SIZE_WORD, 1, 0, 1);
    wr(8'h00, 32'h1000);
    fetch(a, SIZE_BYTE, 1, 0, 0);
    wr(8'h00, 32'h1001);
    fetch(32'h2000, SIZE_WORD, 1, 1, 0);
    fetch(32'h2040, SIZE_WORD, 0, 0, 1);
    fetch(32'h2040, SIZE_WORD, 0, 0, 1);
    fetch(32'h2040, SIZE_WORD, 1, 0, 1);
    fetch(32'h2044, SIZE_WORD, 1, 0, 0);
    wr(8'h00, 32'h5000);
    wr(8'h08, 32'h0);
    for (int i = 0; i < 40; i++) begin
      t = $urandom % 4;
      g = $urandom % 4;
      s = 2'($urandom % 3);
      a = (32'h8000 | t << 7 | g << 5 | ($urandom & 32'h1f)) & ~((32'h1 << s) - 1);
      slow <= 1'($urandom % 2);
      fetch(a, s, 1'($urandom % 2), 0, !res[t][g]);
      res[t][g] = 1'b1;
    end
    slow <= 1'b0;
    wr(8'h00, 32'h5000);
    wr(8'h04, 32'hf800_0000);
    rd(8'h04, v);
    chk(v[31:26], 6'h3e);
    for (int k = 0; k < 3; k++) begin
      fetch(32'h10_0000 + k * 128, SIZE_WORD, 1, 0, 1);
      rd(8'h0c, v);
      chk(v[15:10], 6'h3e + k[0]);
    end
    fetch(32'h10_0080, SIZE_WORD, 1, 0, 0);
    fetch(32'h10_0000, SIZE_WORD, 1, 0, 1);
    wr(8'h00, 32'h1000);
    for (int k = 0; k < 4; k++) begin
      fetch(32'h20_0020 + k * 128, SIZE_WORD, 1, 0, 1);
      rd(8'h0c, v);
      chk(v[15:10] >= 6'h3e, 1'b1);
    end
    fetch(32'h20_01a0, SIZE_WORD, 1, 0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, v);
    chk(v, 32'h0);
    wr(8'h00, 32'h1000);
    fetch(32'h20_01a0, SIZE_WORD, 1, 0, 1);
    fork
      fetch(32'h30_0000, SIZE_WORD, 1, 0, 1);
      begin
        repeat (4) @(posedge clk);
        wr(8'h00, 32'h0);
      end
    join
    wr(8'h00, 32'h1000);
    fetch(32'h30_0000, SIZE_WORD, 1, 0, 1);
    end_of_test;
  end
endmodule

bind icache_ctrl icache_ctrl_sva chk_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_READY(FETCH_READY),
  .FETCH_FAULT(FETCH_FAULT), .BUS_TRANS(BUS_TRANS), .BUS_ADDR(BUS_ADDR),
  .BUS_WAIT(BUS_WAIT));
